// [design/pdsq_pkg.sv]
package pdsq_pkg;

  // Clock
  localparam int CLK_NS = 25;

  // Register map
  localparam int              REG_AW        = 6;
  localparam logic [5:0]      OFS_CTRL      = 6'h00;
  localparam logic [5:0]      OFS_LIM_BASE  = 6'h04;
  localparam logic [5:0]      OFS_SPARK_SET = 6'h14;
  localparam logic [5:0]      OFS_PH_DELAY  = 6'h18;
  localparam logic [5:0]      OFS_STATUS    = 6'h1c;
  localparam logic [5:0]      OFS_IRQ_STAT  = 6'h20;
  localparam logic [5:0]      OFS_IRQ_EN    = 6'h24;
  localparam logic [5:0]      OFS_IRQ_CLR   = 6'h28;

  // Control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SPARK_BIT  = 1;

  // Interrupt event positions
  localparam int IRQ_OVERCURRENT = 0;
  localparam int IRQ_LIMIT       = 1;
  localparam int IRQ_SPARK       = 2;
  localparam int IRQ_BLOCK       = 3;
  localparam int IRQ_N           = 4;

  // Monitored channels
  localparam int LIM_N = 4;

  // Times in ns
  localparam int T_START_NS    = 250;
  localparam int T_STOP_NS     = 250;
  localparam int T_HOLD_NS     = 100000;
  localparam int T_DETECT_NS   = 3000;
  localparam int T_OSC_HALF_NS = 1250;

  // Cycle counts
  localparam logic [15:0] START_CYC    = 16'((T_START_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] STOP_CYC     = 16'((T_STOP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] HOLD_CYC     = 16'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] DETECT_CYC   = 16'((T_DETECT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] OSC_HALF_CYC = 16'(T_OSC_HALF_NS / CLK_NS);

  // Reset values
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam logic [15:0] PH_DELAY_RST = 16'h0004;
  localparam logic [15:0] LIM_RST      = 16'hffff;

endpackage

// [design/pdsq_sync.sv]
module pdsq_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

// [design/pdsq_oneshot.sv]
module pdsq_oneshot #(
  parameter int CW = 16
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          ce,
  input  wire logic          trig,
  input  wire logic [CW-1:0] width,
  output logic               busy
);

  logic [CW-1:0] cnt_q;

  // Retriggerable down counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (trig) begin
        cnt_q <= width;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign busy = (cnt_q != '0);

  a_shot_loads: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    (trig && width > 1) |=> busy)
    else $error("One-shot did not start on trigger");

endmodule

// [design/pdsq_top.sv]
// Function
// - Zero-crossing pulses drive actuation while current is detected, else the oscillator.
// - Averaged overcurrent blocks actuation and holds the block for a minimum time.
// - Software loads four limit words and each measurement is compared with its limit.
// - Any limit violation blocks actuation and starts a second minimum hold.
// - The stage is blocked unless enabled, interlock granted and processor not in reset.
// - With spark regulation on, spark excess lights an indicator and blocks for the hold.
// - From off, the sequence is start A, stop A, start B, stop B, repeating.
// - Every edge of the selected zero-crossing signal gives one short pulse.
// - Doubled pulses are extended by a programmable phase delay.
// - A toggle halves the pulses into a 1:1 select, high for A, inverted for B.
// - Separate one-shots make the start and the stop pulse for the selected transistor.
// - Without start permit all starts are suppressed while stops still pass.
// - Both transistors are never commanded on together and stop wins over start.
// - Current detect is a retriggerable timer slightly longer than one HF period.
module pdsq_top
  import pdsq_pkg::*;
#(
  parameter int DW = 16,
  parameter int MW = 16
) (
  input  wire logic              CLK,
  input  wire logic              RST_B,
  input  wire logic              CE,
  input  wire logic [REG_AW-1:0] ADDR,
  input  wire logic [DW-1:0]     WR_DATA,
  input  wire logic              WR_EN,
  input  wire logic              RD_EN,
  output logic      [DW-1:0]     RD_DATA,
  input  wire logic              ZC_CMP,
  input  wire logic              OVC_CMP,
  input  wire logic              INTERLOCK_OK,
  input  wire logic              CPU_RESET,
  input  wire logic              START_PERMIT,
  input  wire logic [MW-1:0]     PATIENT_VOLTAGE_MEAS,
  input  wire logic [MW-1:0]     PATIENT_CURRENT_MEAS,
  input  wire logic [MW-1:0]     SUPPLY_VOLTAGE_MEAS,
  input  wire logic [MW-1:0]     SUPPLY_CURRENT_MEAS,
  input  wire logic [MW-1:0]     SPARK_LEVEL_MEAS,
  output logic                   SEL_A,
  output logic                   SEL_B,
  output logic                   START_PULSE,
  output logic                   STOP_PULSE,
  output logic                   SPARK_LED,
  output logic                   IRQ
);

  logic              rst_m_q;
  logic              rst_n;
  logic [4:0]        bits_s;
  logic              zc_s;
  logic              ovc_s;
  logic              intlk_s;
  logic              cpurst_s;
  logic              permit_s;
  logic [5*MW-1:0]   words_s;
  logic [MW-1:0]     meas [LIM_N];
  logic [MW-1:0]     spark_s;
  logic [1:0]        ctrl_q;
  logic [DW-1:0]     lim_q [LIM_N];
  logic [DW-1:0]     spark_set_q;
  logic [DW-1:0]     ph_delay_q;
  logic [IRQ_N-1:0]  irq_st_q;
  logic [IRQ_N-1:0]  irq_en_q;
  logic [IRQ_N-1:0]  irq_ev;
  logic [IRQ_N-1:0]  irq_clr;
  logic [LIM_N-1:0]  viol;
  logic              spark_ex;
  logic              det_busy;
  logic              ovc_busy;
  logic              lim_busy;
  logic              ph_busy;
  logic              ph_busy_d_q;
  logic              start_busy;
  logic              stop_busy;
  logic              stop_busy_d_q;
  logic [15:0]       osc_cnt_q;
  logic              osc_q;
  logic              src;
  logic              src_d_q;
  logic              dbl_q;
  logic              evt;
  logic              blk_d;
  logic              blk_q;
  logic              on_q;
  logic              sel_a_q;
  logic              start_trig;
  logic              stop_trig;
  logic [DW-1:0]     rd_d;

  // Reset release
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_m_q <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_n   <= rst_m_q;
    end
  end

  // Input synchronisers
  pdsq_sync #(.W(5)) u_sync_bits (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .d     ({ZC_CMP, OVC_CMP, INTERLOCK_OK, CPU_RESET, START_PERMIT}),
    .q     (bits_s)
  );
  assign {zc_s, ovc_s, intlk_s, cpurst_s, permit_s} = bits_s;

  pdsq_sync #(.W(5*MW)) u_sync_words (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .d     ({SPARK_LEVEL_MEAS, SUPPLY_CURRENT_MEAS, SUPPLY_VOLTAGE_MEAS,
             PATIENT_CURRENT_MEAS, PATIENT_VOLTAGE_MEAS}),
    .q     (words_s)
  );
  assign spark_s = words_s[4*MW +: MW];

  // Limit comparators
  genvar gi;
  generate
    for (gi = 0; gi < LIM_N; gi++) begin : g_lim
      assign meas[gi] = words_s[gi*MW +: MW];
      assign viol[gi] = (DW'(meas[gi]) > lim_q[gi]);
    end
  endgenerate

  assign spark_ex = ctrl_q[CTRL_SPARK_BIT] && (DW'(spark_s) > spark_set_q);

  // Register writes
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q      <= CTRL_RST;
      spark_set_q <= '1;
      ph_delay_q  <= DW'(PH_DELAY_RST);
      irq_en_q    <= '0;
      for (int i = 0; i < LIM_N; i++) begin
        lim_q[i] <= DW'(LIM_RST);
      end
    end else if (CE && WR_EN) begin
      case (ADDR)
        OFS_CTRL:      ctrl_q      <= WR_DATA[1:0];
        OFS_SPARK_SET: spark_set_q <= WR_DATA;
        OFS_PH_DELAY:  ph_delay_q  <= WR_DATA;
        OFS_IRQ_EN:    irq_en_q    <= WR_DATA[IRQ_N-1:0];
        default: begin
          for (int i = 0; i < LIM_N; i++) begin
            if (ADDR == OFS_LIM_BASE + REG_AW'(4 * i)) begin
              lim_q[i] <= WR_DATA;
            end
          end
        end
      endcase
    end
  end

  // Sticky interrupt status, set wins over clear
  assign irq_clr = (WR_EN && ADDR == OFS_IRQ_CLR) ? WR_DATA[IRQ_N-1:0] : '0;
  assign irq_ev  = {blk_d && !blk_q, spark_ex, |viol, ovc_s};

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
      IRQ      <= 1'b0;
    end else if (CE) begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      IRQ      <= |(irq_st_q & irq_en_q);
    end
  end

  // Register reads
  always_comb begin
    rd_d = '0;
    case (ADDR)
      OFS_CTRL:      rd_d = DW'(ctrl_q);
      OFS_SPARK_SET: rd_d = spark_set_q;
      OFS_PH_DELAY:  rd_d = ph_delay_q;
      OFS_STATUS:    rd_d = DW'({SPARK_LED, det_busy, on_q, sel_a_q, blk_q});
      OFS_IRQ_STAT:  rd_d = DW'(irq_st_q);
      OFS_IRQ_EN:    rd_d = DW'(irq_en_q);
      default: begin
        for (int i = 0; i < LIM_N; i++) begin
          if (ADDR == OFS_LIM_BASE + REG_AW'(4 * i)) begin
            rd_d = lim_q[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      RD_DATA <= '0;
    end else if (CE) begin
      RD_DATA <= RD_EN ? rd_d : '0;
    end
  end

  // Safety holds
  pdsq_oneshot u_ovc_hold (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  (ovc_s),
    .width (HOLD_CYC),
    .busy  (ovc_busy)
  );

  pdsq_oneshot u_lim_hold (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  ((|viol) || spark_ex),
    .width (HOLD_CYC),
    .busy  (lim_busy)
  );

  assign blk_d = ovc_s || ovc_busy || (|viol) || spark_ex || lim_busy
              || !ctrl_q[CTRL_ENABLE_BIT] || !intlk_s || cpurst_s;

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      blk_q     <= 1'b1;
      SPARK_LED <= 1'b0;
    end else if (CE) begin
      blk_q     <= blk_d;
      SPARK_LED <= spark_ex;
    end
  end

  // Current detect and start oscillator
  pdsq_oneshot u_detect (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  (zc_s),
    .width (DETECT_CYC),
    .busy  (det_busy)
  );

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_q <= '0;
      osc_q     <= 1'b0;
    end else if (CE) begin
      if (osc_cnt_q >= OSC_HALF_CYC - 16'h0001) begin
        osc_cnt_q <= '0;
        osc_q     <= ~osc_q;
      end else begin
        osc_cnt_q <= osc_cnt_q + 16'h0001;
      end
    end
  end

  assign src = det_busy ? zc_s : osc_q;

  // Edge doubler and phase delay
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      src_d_q       <= 1'b0;
      dbl_q         <= 1'b0;
      ph_busy_d_q   <= 1'b0;
      stop_busy_d_q <= 1'b0;
    end else if (CE) begin
      src_d_q       <= src;
      dbl_q         <= src ^ src_d_q;
      ph_busy_d_q   <= ph_busy;
      stop_busy_d_q <= stop_busy;
    end
  end

  pdsq_oneshot u_phase (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  (dbl_q),
    .width (16'(ph_delay_q) + 16'h0001),
    .busy  (ph_busy)
  );

  assign evt = ph_busy_d_q && !ph_busy;

  // Start/stop sequencing
  assign start_trig = evt && !on_q && !blk_q && permit_s
                   && !stop_busy && !stop_busy_d_q;
  assign stop_trig  = (evt && on_q) || (blk_q && on_q);

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      on_q    <= 1'b0;
      sel_a_q <= 1'b1;
    end else if (CE) begin
      if (start_trig) begin
        on_q <= 1'b1;
      end else if (stop_trig) begin
        on_q <= 1'b0;
      end
      // Select held until a pending stop has reached its transistor
      if (blk_q && !on_q && !stop_busy && !stop_busy_d_q) begin
        sel_a_q <= 1'b1;
      end else if (!blk_q && stop_busy_d_q && !stop_busy) begin
        sel_a_q <= ~sel_a_q;
      end
    end
  end

  pdsq_oneshot u_start (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  (start_trig),
    .width (START_CYC),
    .busy  (start_busy)
  );

  pdsq_oneshot u_stop (
    .clk   (CLK),
    .rst_n (rst_n),
    .ce    (CE),
    .trig  (stop_trig),
    .width (STOP_CYC),
    .busy  (stop_busy)
  );

  // Drive outputs
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      SEL_A       <= 1'b1;
      SEL_B       <= 1'b0;
      START_PULSE <= 1'b0;
      STOP_PULSE  <= 1'b0;
    end else if (CE) begin
      SEL_A       <= sel_a_q;
      SEL_B       <= ~sel_a_q;
      START_PULSE <= start_busy && !stop_busy && !blk_q && permit_s;
      STOP_PULSE  <= stop_busy;
    end
  end

  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n || !CE);

  sequence s_stop_end;
    stop_busy_d_q && !stop_busy && !blk_q;
  endsequence

  sequence s_block_idle;
    blk_q && !on_q && !stop_busy && !stop_busy_d_q;
  endsequence

  a_no_overlap: assert property (!(START_PULSE && STOP_PULSE))
    else $error("Start and stop pulse together");
  a_sel_exclusive: assert property (SEL_A != SEL_B)
    else $error("Both selects equal");
  a_block_no_start: assert property (blk_q |=> !START_PULSE)
    else $error("Start pulse while blocked");
  a_ovc_blocks: assert property (ovc_s |=> blk_q [*8])
    else $error("Overcurrent hold too short");
  a_limit_blocks: assert property (|viol |=> blk_q [*8])
    else $error("Limit hold too short");
  a_spark_led: assert property (spark_ex |=> SPARK_LED && blk_q)
    else $error("Spark excess not flagged");
  a_dbl_pulse: assert property ($changed(src) |=> dbl_q)
    else $error("Edge did not make a pulse");
  a_detect_hold: assert property (zc_s |=> det_busy [*8])
    else $error("Current detect dropped");
  a_sel_flip: assert property (s_stop_end |=> sel_a_q != $past(sel_a_q))
    else $error("Select did not toggle after stop");
  a_block_restart: assert property (s_block_idle |=> ##1 SEL_A)
    else $error("Select not back to A while blocked");
  a_stop_keeps_sel: assert property (stop_busy |=> $stable(sel_a_q))
    else $error("Select changed during a stop pulse");
  a_permit_gate: assert property (!permit_s |=> !START_PULSE)
    else $error("Start without permit");

endmodule

// [test/pdsq_gate_model.sv]
module pdsq_gate_model
  import pdsq_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sel_a,
  input  wire logic sel_b,
  input  wire logic start_p,
  input  wire logic stop_p,
  output int        sa_cnt,
  output int        sb_cnt,
  output int        flt
);
  logic on_a = 1'b0;
  logic on_b = 1'b0;
  logic last_a = 1'b1;
  logic start_q = 1'b0;
  logic stop_q = 1'b0;
  int   w1 = 0;
  int   w2 = 0;
  int   cut = 0;
  logic go_a;
  logic go_b;

  initial begin
    sa_cnt = 0;
    sb_cnt = 0;
    flt = 0;
  end

  // Gate drivers turn select plus start/stop into four drive pulses
  always @(posedge clk) begin
    go_a = start_p && !start_q && sel_a && !stop_p;
    go_b = start_p && !start_q && sel_b && !stop_p;
    if (rst_n && (sel_a === sel_b)) flt++;
    if ((go_a && on_b) || (go_b && on_a)) flt++;
    if (go_b && !last_a) flt++;
    if (stop_p && !stop_q) begin
      if (sel_a) begin
        on_a = 1'b0;
        last_a = 1'b1;
      end
      if (sel_b) begin
        on_b = 1'b0;
        last_a = 1'b0;
      end
    end
    on_a = on_a || go_a;
    on_b = on_b || go_b;
    sa_cnt += int'(go_a);
    sb_cnt += int'(go_b);
    // A cut start must be followed by a stop
    if (cut > 0) begin
      cut--;
      if (stop_p) cut = 0;
      else if (cut == 0) flt++;
    end
    if (start_p) w1++;
    else if (start_q) begin
      if (w1 > START_CYC) flt++;
      else if (w1 < START_CYC) cut = 3;
      w1 = 0;
    end
    if (stop_p) w2++;
    else if (stop_q) begin
      if (w2 != STOP_CYC) flt++;
      w2 = 0;
    end
    start_q = start_p;
    stop_q = stop_p;
  end
endmodule

// [test/pdsq_top_tb.sv]
module pdsq_top_tb
  import pdsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [5:0]  RST_A [9] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18,
                                         6'h28, 6'h3c};
  localparam logic [15:0] RST_V [9] = '{16'h0000, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                                         16'hffff, 16'h0004, 16'h0000, 16'h0000};
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic [5:0]  addr = '0;
  logic [15:0] wr_data = '0;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic        zc = 1'b0;
  logic        ovc = 1'b0;
  logic        ilk = 1'b1;
  logic        cpu_rst = 1'b0;
  logic        permit = 1'b1;
  logic [15:0] pv = '0;
  logic [15:0] sc = '0;
  logic [15:0] spk = '0;
  logic [15:0] rd_data;
  logic        sel_a, sel_b, start_p, stop_p, led, irq;
  logic [15:0] exp_q[$];
  logic [15:0] msk_q[$];
  logic        rd_p1 = 1'b0;
  int          fail_count = 0;
  int          checks_done = 0;
  int          sa_cnt, sb_cnt, flt, snap, snap_a;

  pdsq_top pdsq_top_i (.CLK(clk), .RST_B(rst_b), .CE(ce), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data), .ZC_CMP(zc), .OVC_CMP(ovc),
    .INTERLOCK_OK(ilk), .CPU_RESET(cpu_rst), .START_PERMIT(permit),
    .PATIENT_VOLTAGE_MEAS(pv), .PATIENT_CURRENT_MEAS(pv), .SUPPLY_VOLTAGE_MEAS(pv),
    .SUPPLY_CURRENT_MEAS(sc), .SPARK_LEVEL_MEAS(spk), .SEL_A(sel_a), .SEL_B(sel_b),
    .START_PULSE(start_p), .STOP_PULSE(stop_p), .SPARK_LED(led), .IRQ(irq));

  pdsq_gate_model pdsq_gate_model_i (.clk(clk), .rst_n(rst_b), .sel_a(sel_a), .sel_b(sel_b),
    .start_p(start_p), .stop_p(stop_p), .sa_cnt(sa_cnt), .sb_cnt(sb_cnt), .flt(flt));

  initial forever #12.5 clk = ~clk;

  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic cmp_ok(input bit ok, input string m);
    checks_done++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  // Read data stand in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_p1) cmp_val(rd_data & msk_q.pop_front(), exp_q.pop_front(), "read");
    rd_p1 <= rd_en;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e, input logic [15:0] m);
    @(posedge clk);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
  endtask

  task automatic zc_run(input int n);
    repeat (n) begin
      cyc(40);
      zc <= ~zc;
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    cyc(60000);
    fail_count++;
    end_sim;
  end

  initial begin
    logic [15:0] r;
    void'($urandom(30234));
    cyc(8);
    rst_b <= 1'b1;
    cyc(4);
    foreach (RST_A[i]) rd(RST_A[i], RST_V[i], 16'hffff);
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom);
      wr(OFS_LIM_BASE + 6'(4 * i), r);
      rd(OFS_LIM_BASE + 6'(4 * i), r, 16'hffff);
    end
    r = 16'($urandom_range(2, 12));
    wr(OFS_PH_DELAY, r);
    rd(OFS_PH_DELAY, r, 16'hffff);
    wr(OFS_CTRL, 16'h0001);
    cyc(HOLD_CYC + 100);
    rd(OFS_STATUS, 16'h0000, 16'h0001);
    cyc(600);
    cmp_ok(sa_cnt > 0 && sb_cnt > 0, "oscillator run");
    zc_run(10);
    rd(OFS_STATUS, 16'h0008, 16'h0008);
    cyc(200);
    rd(OFS_STATUS, 16'h0000, 16'h0008);
    wait (stop_p);
    @(posedge clk);
    permit <= 1'b0;
    cyc(30);
    snap = sa_cnt + sb_cnt;
    zc_run(10);
    cmp_ok(sa_cnt + sb_cnt == snap, "start without permit");
    permit <= 1'b1;
    wr(OFS_LIM_BASE + 6'h0c, 16'h0100);
    sc <= 16'h0100 + 16'($urandom_range(1, 255));
    cyc(10);
    snap = sa_cnt + sb_cnt;
    rd(OFS_STATUS, 16'h0001, 16'h0001);
    rd(OFS_IRQ_STAT, 16'h0002, 16'h0002);
    wr(OFS_IRQ_EN, 16'h0002);
    cyc(3);
    cmp_val({15'h0, irq}, 16'h0001, "irq raised");
    wr(OFS_IRQ_EN, 16'h0000);
    cyc(3);
    cmp_val({15'h0, irq}, 16'h0000, "irq masked");
    sc <= '0;
    cyc(10);
    wr(OFS_IRQ_CLR, 16'h0002);
    rd(OFS_IRQ_STAT, 16'h0000, 16'h0002);
    cyc(200);
    rd(OFS_STATUS, 16'h0003, 16'h0003);
    cmp_ok(sa_cnt + sb_cnt == snap, "start while blocked");
    snap_a = sa_cnt;
    for (int k = 0; k < 4500 && sa_cnt + sb_cnt == snap; k++) cyc(1);
    cmp_ok(sa_cnt == snap_a + 1, "restart on A");
    rd(OFS_STATUS, 16'h0000, 16'h0001);
    ovc <= 1'b1;
    cyc(10);
    rd(OFS_STATUS, 16'h0001, 16'h0001);
    rd(OFS_IRQ_STAT, 16'h0001, 16'h0001);
    ovc <= 1'b0;
    cyc(200);
    rd(OFS_STATUS, 16'h0001, 16'h0001);
    cyc(HOLD_CYC);
    wr(OFS_SPARK_SET, 16'h0100);
    wr(OFS_CTRL, 16'h0003);
    spk <= 16'h0200;
    cyc(10);
    cmp_val({15'h0, led}, 16'h0001, "spark led on");
    rd(OFS_IRQ_STAT, 16'h0004, 16'h0004);
    rd(OFS_STATUS, 16'h0011, 16'h0011);
    spk <= '0;
    cyc(10);
    cmp_val({15'h0, led}, 16'h0000, "spark led off");
    cyc(HOLD_CYC);
    for (int i = 0; i < 3; i++) begin
      if (i == 0) wr(OFS_CTRL, 16'h0000);
      else if (i == 1) ilk <= 1'b0;
      else cpu_rst <= 1'b1;
      cyc(10);
      rd(OFS_STATUS, 16'h0001, 16'h0001);
      wr(OFS_CTRL, 16'h0001);
      ilk <= 1'b1;
      cpu_rst <= 1'b0;
      cyc(HOLD_CYC + 100);
      rd(OFS_STATUS, 16'h0000, 16'h0001);
    end
    cyc(4);
    cmp_ok(flt == 0, "gate driver model");
    end_sim;
  end
endmodule
